/* File: verilog/cbc_clock_ctrl.sv */
// Core clock source selection, bus clock divider, reset timing and idle/sleep control
//
// Overview of operation
// - Three modes: normal, idle, sleep
// - Idle stops execution, PLL keeps running
// - Sleep: outputs low, inverted pin high with external clock, memory request high
// - PLL multiplies crystal, runs normal and idle
// - Core and bus interface clock domains
// - Switching on: fast clock except fill wait
// - Reset disables switching, core uses bus clock
// - Leave reset 150 us after pins release
// - Coprocessor write minor 2 disables, 1 enables
// - Disable freezes source; miss moves to bus
// - Source select drives divided bus clock
// - Synchronise bus clock into fast domain
// - Inverted copy on at reset, minor 4 off
// - Bus clocks start 10 us before reset out
// - External bus clock holds inverted pin high
// - External clock: idle request ignored, no parking
// - Sourced clock idle parks low until interrupt
// - Core strap codes 0-11 choose PLL frequency
// - Bus divisor is strap plus two, high for half rounded down
`default_nettype none
module cbc_clock_ctrl
    import cbc_pkg::*;
#(
    parameter int RST_CYCLES = RST_WAIT_CYC
)(
    // Clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        nrst_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic             hreadyout_out,
    output logic             hresp_out,
    output logic [31:0]      hrdata_out,
    // Straps and system pins
    input  wire logic        bus_clock_source_select_in,
    input  wire logic [2:0]  bus_divisor_straps_in,
    input  wire logic [3:0]  core_freq_straps_in,
    input  wire logic        reset_input_low_in,
    input  wire logic        power_sleep_low_in,
    input  wire logic        fast_interrupt_low_in,
    input  wire logic        normal_interrupt_low_in,
    // Core side
    input  wire logic        cache_miss_wait_in,
    input  wire logic        memory_request_low_in,
    output logic             memory_request_low_out,
    output logic             exec_enable_out,
    output logic             core_domain_clock_out,
    output logic             core_clock_from_bus_out,
    output logic             pll_run_out,
    output logic [11:0]      pll_freq_tenth_mhz_out,
    output logic             core_strap_bad_out,
    // Bus clock pins
    input  wire logic        bus_clock_in,
    output logic             bus_clock_out,
    output logic             bus_clock_oe_n_out,
    output logic             inverted_bus_clock_out,
    output logic             reset_output_low_out
);

    // Fast clock frequency per strap code, tenths of a MHz (lowest to highest)
    function automatic logic [11:0] freq_of(input logic [3:0] code);
        case (code)
            4'h0:    freq_of = 12'h359;
            4'h1:    freq_of = 12'h39F;
            4'h2:    freq_of = 12'h3C4;
            4'h3:    freq_of = 12'h40B;
            4'h4:    freq_of = 12'h570;
            4'h5:    freq_of = 12'h5B8;
            4'h6:    freq_of = 12'h623;
            4'h7:    freq_of = 12'h66A;
            4'h8:    freq_of = 12'h740;
            4'h9:    freq_of = 12'h7AB;
            4'hA:    freq_of = 12'h816;
            4'hB:    freq_of = 12'h8A5;
            default: freq_of = 12'h000;
        endcase
    endfunction

    localparam logic [15:0] RST_LAST   = 16'(RST_CYCLES - 1);
    localparam logic [15:0] BCLK_START = 16'(RST_CYCLES - BCLK_LEAD_CYC);

    cbc_state_s s_reg;
    cbc_state_s s_next;

    logic        pins_reset;
    logic        sourcing;
    logic        bclk_run;
    logic        any_irq;
    logic [3:0]  divisor;
    logic [3:0]  half_div;
    logic        ahb_go;
    logic        bus_rise_ext;
    logic [31:0] status_word;
    logic        cp_write;

    // Combinational helpers
    assign pins_reset   = !reset_input_low_in || !power_sleep_low_in;
    assign sourcing     = bus_clock_source_select_in;
    assign any_irq      = !fast_interrupt_low_in || !normal_interrupt_low_in;
    assign divisor      = {1'b0, s_reg.bus_div_code} + BUS_DIV_BASE;
    assign half_div     = divisor >> 1;
    assign ahb_go       = hsel_in && hready_in && htrans_in[1];
    assign bus_rise_ext = s_reg.sync2 && !s_reg.sync3;
    assign cp_write     = s_reg.wr_pend && s_reg.wr_addr == OFS_CPWR &&
                          hwdata_in[CPW_OPC_LSB +: 3] == OPC2_CLKCTL;
    // Bus clock runs when sourced, from the lead point of wake-up until parked, sleep or reset
    assign bclk_run     = sourcing && !s_reg.park &&
                          (s_reg.mode == MODE_NORMAL || s_reg.mode == MODE_IDLE ||
                           (s_reg.mode == MODE_WAKE && s_reg.rst_cnt >= BCLK_START));

    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[ST_MODE_LSB +: 3] = s_reg.mode;
        status_word[ST_SWEN_BIT]      = s_reg.sw_en;
        status_word[ST_SRC_BIT]       = s_reg.src_bus;
        status_word[ST_INV_BIT]       = s_reg.inv_en;
        status_word[ST_PARK_BIT]      = s_reg.park;
        status_word[ST_BAD_BIT]       = (s_reg.freq_code > LAST_GOOD_CODE);
        status_word[ST_FREQ_LSB +: 12] = freq_of(s_reg.freq_code);
    end

    // Next-state logic for the whole controller
    always_comb
    begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        // Bus clock pin sampled through two flops before any use
        s_next.sync1 = bus_clock_in;
        s_next.sync2 = s_reg.sync1;
        s_next.sync3 = s_reg.sync2;

        // AHB address phase: read data prepared now so it stands in the data phase
        s_next.wr_pend = ahb_go && hwrite_in;
        s_next.wr_addr = haddr_in[7:0];
        if (ahb_go && !hwrite_in)
        begin
            s_next.rdata = (haddr_in[7:0] == OFS_STATUS) ? status_word : 32'h0000_0000;
        end

        // Mode sequencing
        case (s_reg.mode)
            MODE_RESET, MODE_SLEEP:
            begin
                s_next.rst_cnt = 16'h0000;
                if (!pins_reset)
                    s_next.mode = MODE_WAKE;
            end
            MODE_WAKE:
            begin
                s_next.rst_cnt = s_reg.rst_cnt + 16'h0001;
                if (s_reg.rst_cnt == RST_LAST)
                    s_next.mode = MODE_NORMAL;
            end
            MODE_NORMAL:
            begin
                if (s_reg.park)
                    s_next.mode = MODE_IDLE;
            end
            MODE_IDLE:
            begin
                if (!s_reg.park)
                    s_next.mode = MODE_NORMAL;
            end
            default: s_next.mode = MODE_RESET;
        endcase

        // Straps are sampled while the device sits in reset
        if (s_reg.mode != MODE_NORMAL && s_reg.mode != MODE_IDLE)
        begin
            s_next.freq_code    = core_freq_straps_in;
            s_next.bus_div_code = bus_divisor_straps_in;
        end

        // Core clock source: bus clock in reset; with switching on, fast clock unless waiting on a fill
        if (s_reg.mode != MODE_NORMAL && s_reg.mode != MODE_IDLE)
            s_next.src_bus = RST_SRC_BUS;
        else if (s_reg.sw_en)
            s_next.src_bus = cache_miss_wait_in;
        else if (cache_miss_wait_in)
            s_next.src_bus = 1'b1;

        // Software writes, data phase; a coprocessor write is emulated over the bus
        if (cp_write)
        begin
            case (hwdata_in[CPW_MIN_LSB +: 4])
                MIN_SW_DIS:  s_next.sw_en  = 1'b0;
                MIN_SW_EN:   s_next.sw_en  = 1'b1;
                MIN_INV_DIS: s_next.inv_en = 1'b0;
                default:     s_next.sw_en  = s_reg.sw_en;
            endcase
        end
        if (s_reg.wr_pend && s_reg.wr_addr == OFS_CTRL && hwdata_in[CTRL_WFI_BIT] &&
            sourcing && s_reg.mode == MODE_NORMAL)
            s_next.wfi_pend = 1'b1;

        // Sourced bus clock divider; parking only happens in the low phase
        if (bclk_run)
        begin
            s_next.div_cnt = (s_reg.div_cnt >= divisor - 4'h1) ? 4'h0
                                                               : s_reg.div_cnt + 4'h1;
            s_next.bclk = (s_next.div_cnt < half_div);
        end
        else if (!s_reg.park)
        begin
            s_next.div_cnt = 4'h0;
            s_next.bclk    = 1'b0;
        end
        // Park on the coming level, else a low-to-high step could freeze the pin high
        if (s_reg.wfi_pend && !s_next.bclk && !s_reg.park)
        begin
            s_next.park     = 1'b1;
            s_next.wfi_pend = 1'b0;
        end
        if (s_reg.park && any_irq)
            s_next.park = 1'b0;

        // Core domain clock enable follows the selected source
        if (!s_reg.src_bus)
            s_next.tick = 1'b1;
        else if (sourcing)
            s_next.tick = s_next.bclk && !s_reg.bclk;
        else
            s_next.tick = bus_rise_ext;

        // Reset and sleep pins restart mode, clock control and divider state; the sleep pin enters sleep mode
        if (pins_reset)
        begin
            s_next.mode     = power_sleep_low_in ? MODE_RESET : MODE_SLEEP;
            s_next.sw_en    = RST_SW_EN;
            s_next.inv_en   = RST_INV_EN;
            s_next.src_bus  = RST_SRC_BUS;
            s_next.park     = 1'b0;
            s_next.wfi_pend = 1'b0;
            s_next.rst_cnt  = 16'h0000;
            s_next.div_cnt  = 4'h0;
            s_next.bclk     = 1'b0;
        end
    end

    // State register; async reset loads constants only
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s_reg          <= '0;
            s_reg.mode     <= MODE_RESET;
            s_reg.sw_en    <= RST_SW_EN;
            s_reg.src_bus  <= RST_SRC_BUS;
            s_reg.inv_en   <= RST_INV_EN;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    // AHB response: zero wait states, always OKAY
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = s_reg.rdata;

    // Core-facing outputs
    assign exec_enable_out         = (s_reg.mode == MODE_NORMAL);
    assign core_domain_clock_out   = s_reg.tick && (s_reg.mode != MODE_SLEEP);
    assign core_clock_from_bus_out = s_reg.src_bus;
    assign pll_run_out             = (s_reg.mode != MODE_SLEEP);
    assign pll_freq_tenth_mhz_out  = freq_of(s_reg.freq_code);
    assign core_strap_bad_out      = (s_reg.freq_code > LAST_GOOD_CODE);
    assign reset_output_low_out    = (s_reg.mode == MODE_NORMAL ||
                                      s_reg.mode == MODE_IDLE);
    assign memory_request_low_out  = (s_reg.mode == MODE_SLEEP) ? 1'b1
                                                                : memory_request_low_in;

    // Bus clock pins; the pin is only driven when this end sources it
    assign bus_clock_out      = s_reg.bclk;
    assign bus_clock_oe_n_out = !sourcing;
    // Inverted copy toggles with the clock, held high with an external clock
    assign inverted_bus_clock_out = !sourcing ? 1'b1 :
                                    (s_reg.mode == MODE_SLEEP || !s_reg.inv_en) ? 1'b0 :
                                    (bclk_run || s_reg.bclk) ? !s_reg.bclk : 1'b0;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!nrst_in);

    a_reset_out_timing: assert property (
        (s_reg.mode == MODE_WAKE && s_reg.rst_cnt == RST_LAST && !pins_reset)
        |=> reset_output_low_out)
        else $error("reset output not released at end of wait");
    a_reset_out_held: assert property (
        (s_reg.mode == MODE_WAKE) |-> !reset_output_low_out)
        else $error("reset output released during wait");
    a_reset_bus_source: assert property (
        pins_reset |=> (core_clock_from_bus_out && !s_reg.sw_en))
        else $error("reset did not select bus clock with switching off");
    a_miss_to_bus: assert property (
        (reset_output_low_out && !pins_reset && cache_miss_wait_in) |=> core_clock_from_bus_out)
        else $error("cache miss did not move core clock to bus clock");
    a_fast_when_on: assert property (
        (s_reg.sw_en && reset_output_low_out && !pins_reset && !cache_miss_wait_in)
        |=> !core_clock_from_bus_out)
        else $error("switching enabled but fast clock not selected");
    a_freeze_source: assert property (
        (!s_reg.sw_en && reset_output_low_out && !pins_reset && !cache_miss_wait_in)
        |=> $stable(core_clock_from_bus_out))
        else $error("source changed while switching disabled");
    a_sleep_pins: assert property (
        (s_reg.mode == MODE_SLEEP) |-> (memory_request_low_out && !bus_clock_out &&
                                         !reset_output_low_out && !exec_enable_out))
        else $error("sleep pin levels wrong");
    a_inv_external: assert property (
        !sourcing |-> inverted_bus_clock_out)
        else $error("inverted clock not high with external clock");
    a_park_release: assert property (
        (s_reg.park && any_irq && !pins_reset) |=> !s_reg.park
        ##1 (s_reg.mode == MODE_NORMAL))
        else $error("interrupt did not release parked bus clock");
    a_park_low: assert property (
        s_reg.park |-> !bus_clock_out)
        else $error("bus clock not held low while parked");
    a_bad_strap: assert property (
        (s_reg.freq_code > LAST_GOOD_CODE) |-> (pll_freq_tenth_mhz_out == 12'h000))
        else $error("reserved strap code gave a frequency");

    // Software control writes act on the next edge; a pin reset overrides them
    a_sw_dis_write: assert property (
        (cp_write && hwdata_in[CPW_MIN_LSB +: 4] == MIN_SW_DIS && !pins_reset) |=> !s_reg.sw_en)
        else $error("switching not disabled by control write");
    a_sw_en_write: assert property (
        (cp_write && hwdata_in[CPW_MIN_LSB +: 4] == MIN_SW_EN && !pins_reset) |=> s_reg.sw_en)
        else $error("switching not enabled by control write");
    a_inv_dis_write: assert property (
        (cp_write && hwdata_in[CPW_MIN_LSB +: 4] == MIN_INV_DIS && !pins_reset) |=> !s_reg.inv_en)
        else $error("inverted clock not disabled by control write");

    // Mode and clock-source behaviour
    a_idle_no_exec: assert property (
        (s_reg.mode == MODE_IDLE) |-> (!exec_enable_out && pll_run_out))
        else $error("idle mode executes or stops the PLL");
    a_pll_on_run: assert property (
        reset_output_low_out |-> pll_run_out)
        else $error("PLL stopped outside sleep");
    a_sleep_pll: assert property (
        (s_reg.mode == MODE_SLEEP && sourcing) |-> (!pll_run_out && !inverted_bus_clock_out))
        else $error("sleep left PLL or inverted clock active");
    a_tick_fast: assert property (
        (!core_clock_from_bus_out && !pins_reset) |=> core_domain_clock_out)
        else $error("core clock missed an edge on the fast source");
    a_enter_reset: assert property (
        pins_reset |=> (s_reg.mode == MODE_RESET || s_reg.mode == MODE_SLEEP))
        else $error("pin reset did not restart the controller");

    // Straps are static once running; divider and parking stay in range
    a_strap_hold: assert property (
        (s_reg.mode == MODE_NORMAL || s_reg.mode == MODE_IDLE)
        |=> $stable({s_reg.freq_code, s_reg.bus_div_code}))
        else $error("straps resampled while running");
    a_div_range: assert property (
        bclk_run |-> (s_reg.div_cnt < divisor))
        else $error("bus clock divider out of range");
    a_bclk_before_lead: assert property (
        (s_reg.mode == MODE_WAKE && s_reg.rst_cnt < BCLK_START) |-> !bus_clock_out)
        else $error("bus clock started before the lead point");
    a_wfi_needs_src: assert property (
        (!sourcing && !s_reg.wfi_pend) |=> !s_reg.wfi_pend)
        else $error("wait request taken with an external bus clock");

endmodule
`default_nettype wire

/* File: verilog/cbc_pkg.sv */
// Constants, types and register map of the core and bus clock controller
`default_nettype none
package cbc_pkg;
    // Timing
    localparam int          CLK_MHZ       = 250;
    localparam int          RST_WAIT_US   = 150;
    localparam int          BCLK_LEAD_US  = 10;
    localparam int          BCLK_LEAD_CYC = BCLK_LEAD_US * CLK_MHZ;
    localparam int          RST_WAIT_CYC  = RST_WAIT_US * CLK_MHZ;
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL      = 8'h00;
    localparam logic [7:0]  OFS_CPWR      = 8'h04;
    localparam logic [7:0]  OFS_STATUS    = 8'h08;
    // Control register fields
    localparam int          CTRL_WFI_BIT  = 0;
    // Coprocessor write emulation fields and codes
    localparam int          CPW_OPC_LSB   = 0;
    localparam int          CPW_MIN_LSB   = 4;
    localparam logic [2:0]  OPC2_CLKCTL   = 3'h2;
    localparam logic [3:0]  MIN_SW_EN     = 4'h1;
    localparam logic [3:0]  MIN_SW_DIS    = 4'h2;
    localparam logic [3:0]  MIN_INV_DIS   = 4'h4;
    // Status register fields
    localparam int          ST_MODE_LSB   = 0;
    localparam int          ST_SWEN_BIT   = 4;
    localparam int          ST_SRC_BIT    = 5;
    localparam int          ST_INV_BIT    = 6;
    localparam int          ST_PARK_BIT   = 7;
    localparam int          ST_BAD_BIT    = 8;
    localparam int          ST_FREQ_LSB   = 16;
    // Reset values, bus divisor base and last good strap code
    localparam logic        RST_SW_EN     = 1'b0;
    localparam logic        RST_SRC_BUS   = 1'b1;
    localparam logic        RST_INV_EN    = 1'b1;
    localparam logic [3:0]  BUS_DIV_BASE  = 4'h2;
    localparam logic [3:0]  LAST_GOOD_CODE = 4'hB;

    typedef enum logic [2:0] {
        MODE_RESET,
        MODE_SLEEP,
        MODE_WAKE,
        MODE_NORMAL,
        MODE_IDLE
    } cbc_mode_e;

    typedef struct packed {
        cbc_mode_e   mode;
        logic [15:0] rst_cnt;
        logic        sw_en;
        logic        src_bus;
        logic        inv_en;
        logic [3:0]  div_cnt;
        logic        bclk;
        logic        wfi_pend;
        logic        park;
        logic [3:0]  freq_code;
        logic [2:0]  bus_div_code;
        logic        sync1;
        logic        sync2;
        logic        sync3;
        logic        tick;
        logic        wr_pend;
        logic [7:0]  wr_addr;
        logic [31:0] rdata;
    } cbc_state_s;
endpackage
`default_nettype wire

/* File: sim/cbc_partner.sv */
// External bus clock driver and reset/sleep pin sequencer facing the clock controller
`default_nettype none
module cbc_partner (
    // Timing reference for pin changes
    input  wire logic clk_in,
    // Pins toward the device
    output logic      ext_bus_clock_out,
    output logic      reset_low_out,
    output logic      sleep_low_out
);
    timeunit 1ns;
    timeprecision 100ps;

    logic running = 1'h0;

    // Own period, unrelated to the system clock; stands still low when stopped
    initial ext_bus_clock_out = 1'h0;
    always #11 ext_bus_clock_out = running ? ~ext_bus_clock_out : 1'h0;

    // Pins start in reset, as at power-up
    initial
    begin
        reset_low_out = 1'h0;
        sleep_low_out = 1'h1;
    end

    // Start or stop the external bus clock
    task automatic run(input logic on);
        running = on;
    endtask

    task automatic hold_reset();
        @(posedge clk_in);
        reset_low_out <= 1'h0;
    endtask

    // Reset held 24 ns, six cycles, before power-sleep asserts
    task automatic sleep_enter();
        hold_reset();
        repeat (6) @(posedge clk_in);
        sleep_low_out <= 1'h0;
    endtask

    // Both released together; order does not matter to the device
    task automatic release_pins();
        @(posedge clk_in);
        reset_low_out <= 1'h1;
        sleep_low_out <= 1'h1;
    endtask
endmodule
`default_nettype wire

/* File: sim/cbc_clock_ctrl_tb.sv */
// Self-checking bench for the core and bus clock controller
`default_nettype none
module cbc_clock_ctrl_tb;
    import cbc_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int RSTC = 3000;
    logic        clk = 1'h0, nrst = 1'h0, hsel = 1'h1, hwrite = 1'h0, sel = 1'h1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  divs = 3'h2;
    logic [3:0]  frqs = 4'h0;
    logic        fiq_n = 1'h1, irq_n = 1'h1, miss = 1'h0, mreq_n = 1'h0;
    logic        hrdy, hresp, mreq_o, exe, core_domain_clock, from_bus, pll_run, bad;
    logic        bclk, bclk_oe_n, nbclk, rst_out_n, ext_clk, rst_pin_n, slp_pin_n;
    logic [11:0] freq;
    int          n_mismatch = 0, samples_checked = 0, cyc = 0, k;
    int          ft [12] = '{857, 927, 964, 1035, 1392, 1464, 1571, 1642, 1856, 1963,
                             2070, 2213};

    always #2 clk = ~clk;

    cbc_clock_ctrl #(.RST_CYCLES(RSTC)) i_cbc_clock_ctrl (
        .sys_clk_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hrdy), .hreadyout_out(hrdy), .hresp_out(hresp), .hrdata_out(hrdata),
        .bus_clock_source_select_in(sel), .bus_divisor_straps_in(divs),
        .core_freq_straps_in(frqs), .reset_input_low_in(rst_pin_n),
        .power_sleep_low_in(slp_pin_n), .fast_interrupt_low_in(fiq_n),
        .normal_interrupt_low_in(irq_n), .cache_miss_wait_in(miss),
        .memory_request_low_in(mreq_n), .memory_request_low_out(mreq_o),
        .exec_enable_out(exe), .core_domain_clock_out(core_domain_clock),
        .core_clock_from_bus_out(from_bus), .pll_run_out(pll_run),
        .pll_freq_tenth_mhz_out(freq), .core_strap_bad_out(bad), .bus_clock_in(ext_clk),
        .bus_clock_out(bclk), .bus_clock_oe_n_out(bclk_oe_n),
        .inverted_bus_clock_out(nbclk), .reset_output_low_out(rst_out_n));

    cbc_partner i_cbc_partner (.clk_in(clk), .ext_bus_clock_out(ext_clk),
        .reset_low_out(rst_pin_n), .sleep_low_out(slp_pin_n));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // One AHB single transfer; read data lands in st at the data phase edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk); while (hrdy !== 1'h1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hrdy !== 1'h1);
        st = hrdata;
    endtask

    function automatic logic [31:0] cpw(input logic [3:0] m);
        return {24'h0, m, 1'h0, OPC2_CLKCTL};
    endfunction

    // Sum of one output over 8 cycles: 0 bus clock, 1 core clock, 2 inverted
    task automatic tally(input int w, output int n);
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            n += (w == 0) ? bclk : (w == 1) ? core_domain_clock : nbclk;
        end
    endtask

    // Length of the current level run of the bus clock
    task automatic run_len(input logic v, output int n);
        n = 0;
        while (bclk === v && n < 20)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    // Pin reset with new straps, then wake and check timing and divider
    task automatic wake(input logic s, input logic [3:0] c);
        int n, t0, hi, lo, dv;
        logic b;
        i_cbc_partner.hold_reset();
        sel <= s;
        divs <= c[2:0];
        frqs <= c;
        repeat (4) @(posedge clk);
        chk(bad, c > 4'hB);
        chk(freq, (c > 4'hB) ? 0 : ft[c]);
        chk(rst_out_n, 1'h0);
        i_cbc_partner.release_pins();
        n = 0;
        t0 = -1;
        b = bclk;
        while (rst_out_n !== 1'h1 && n < RSTC + 50)
        begin
            @(posedge clk);
            n++;
            if (t0 < 0 && bclk !== b)
                t0 = n;
        end
        chk(n >= RSTC - 2 && n <= RSTC + 8, 1'h1);
        if (s)
        begin
            chk(n - t0 >= BCLK_LEAD_CYC - 12 && n - t0 <= BCLK_LEAD_CYC + 12, 1'h1);
            dv = c[2:0] + 2;
            run_len(1'h1, hi);
            run_len(1'h0, lo);
            run_len(1'h1, hi);
            run_len(1'h0, lo);
            chk(hi, dv / 2);
            chk(lo, dv - dv / 2);
            chk({bclk_oe_n, nbclk}, {1'h0, ~bclk});
        end
        else
            chk({bclk_oe_n, nbclk}, 2'h3);
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            n_mismatch++;
            $display("[ERR] %0t timeout", $time);
            summarize();
        end
    end

    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'h1;
        ahb(1'h0, OFS_STATUS, 32'h0);
        chk(st[ST_INV_BIT:ST_SWEN_BIT], 3'h6);
        chk(from_bus, 1'h1);
        for (int i = 0; i < 16; i++)
            wake(1'h1, i[3:0]);
        wake(1'h1, 4'h2);
        ahb(1'h0, OFS_STATUS, 32'h0);
        chk({st[2:0], exe, pll_run, from_bus}, {MODE_NORMAL, 3'h7});
        chk({hresp, hrdy, mreq_o}, 3'h2);
        ahb(1'h1, OFS_CPWR, cpw(MIN_SW_EN));
        repeat (8) @(posedge clk);
        tally(1, k);
        chk({k[3:0], from_bus}, 5'h10);
        miss <= 1'h1;
        repeat (40) @(posedge clk);
        chk(from_bus, 1'h1);
        miss <= 1'h0;
        repeat (40) @(posedge clk);
        chk(from_bus, 1'h0);
        ahb(1'h1, OFS_CPWR, cpw(MIN_SW_DIS));
        repeat (8) @(posedge clk);
        chk(from_bus, 1'h0);
        miss <= 1'h1;
        repeat (40) @(posedge clk);
        miss <= 1'h0;
        repeat (40) @(posedge clk);
        chk(from_bus, 1'h1);
        ahb(1'h0, 8'h0C, 32'h0);
        chk(st, 32'h0);
        for (int j = 0; j < 2; j++)
        begin
            ahb(1'h1, OFS_CTRL, 32'h1);
            repeat (12) @(posedge clk);
            tally(0, k);
            chk(k, 0);
            ahb(1'h0, OFS_STATUS, 32'h0);
            chk({st[2:0], exe, pll_run}, {MODE_IDLE, 2'h1});
            if (j == 0)
                fiq_n <= 1'h0;
            else
                irq_n <= 1'h0;
            repeat (12) @(posedge clk);
            tally(0, k);
            chk(k != 0, 1'h1);
            fiq_n <= 1'h1;
            irq_n <= 1'h1;
            ahb(1'h0, OFS_STATUS, 32'h0);
            chk(st[2:0], MODE_NORMAL);
        end
        ahb(1'h1, OFS_CPWR, cpw(MIN_INV_DIS));
        repeat (8) @(posedge clk);
        tally(2, k);
        chk(k, 0);
        i_cbc_partner.sleep_enter();
        repeat (4) @(posedge clk);
        chk({mreq_o, exe, pll_run, bclk, nbclk, rst_out_n}, 6'h20);
        ahb(1'h0, OFS_STATUS, 32'h0);
        chk(st[2:0], MODE_SLEEP);
        wake(1'h0, 4'h3);
        ahb(1'h0, OFS_STATUS, 32'h0);
        chk(st[ST_INV_BIT:ST_SWEN_BIT], 3'h6);
        i_cbc_partner.run(1'h1);
        ahb(1'h1, OFS_CPWR, cpw(MIN_SW_DIS));
        miss <= 1'h1;
        repeat (40) @(posedge clk);
        chk(from_bus, 1'h1);
        i_cbc_partner.run(1'h0);
        repeat (12) @(posedge clk);
        tally(1, k);
        chk(k, 0);
        i_cbc_partner.run(1'h1);
        repeat (12) @(posedge clk);
        tally(1, k);
        chk(k != 0, 1'h1);
        miss <= 1'h0;
        ahb(1'h1, OFS_CPWR, cpw(MIN_SW_EN));
        repeat (40) @(posedge clk);
        chk(from_bus, 1'h0);
        summarize();
    end
endmodule
`default_nettype wire
